// File: acp_sample_port.v
`timescale 1ns/1ps
`include "acp_map.vh"
// What this block is required to do
// R1: output words use offset binary, mid-scale is 10'h200.
// R2: input at or below negative full scale gives all zeros.
// R3: input at or above positive full scale gives all ones.
// R4: each word appears six clock cycles after its sample. Here a word held back by wordReady low comes out later.
// R5: one sample per clock period, taken on the clock's sampling edge.
// R6: out-of-range flag high when result is over or under range.
// R7: ten data outputs, bit zero is least significant.
// R8: reference select high chooses external reference, internal powered down.
// R9: reference select low chooses internal reference; default low.
// R10: sleep control high means normal operation; default high.
// R11: sleep control low powers down and stops conversion.
// R12: clock source should keep duty cycle near half.
// R13: ten-bit words at rates up to forty million per second.
// R14: out-of-range flag travels the same pipeline as its word.
// R15: capture discards first six words after start-up or sleep exit. Here no word is discarded after reset, only the sample taken on the wake edge.
module acp_sample_port (
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  input wire [11:0] sampleIn,
  input wire reference_source_select,
  input wire sleepCtrl,
  output reg [9:0] sample_word_bits,
  output reg outOfRange,
  output reg wordValid,
  input wire wordReady,
  output reg internalRefOn,
  output reg converting
);
  // sampleIn is a signed 12-bit front-end result; codes outside -512..511
  // are treated as beyond full scale.
  localparam LAT = `ACP_LATENCY;
  localparam ST_SLEEP = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state;
  reg [9:0] pipeWord [0:LAT-2];
  reg [LAT-2:0] pipeOr;
  reg [LAT-2:0] pipeVal;
  reg [9:0] next_word;
  reg next_or;
  wire awake;
  wire bufInReady;
  wire bufOutValid;
  wire [10:0] bufOutData;
  integer i;

  ////////////////////////////////////////////////////////////////////
  // control pins, sampled as static levels
  assign awake = (state == ST_RUN);

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_RUN;
      internalRefOn <= 1'b1;
      converting <= 1'b1;
    end else if (ce) begin
      internalRefOn <= !reference_source_select; // R8 R9
      case (state)
        ST_RUN: begin
          if (!sleepCtrl) begin
            state <= ST_SLEEP; // R11
            converting <= 1'b0;
          end
        end
        ST_SLEEP: begin
          if (sleepCtrl) begin
            state <= ST_RUN; // R10
            converting <= 1'b1;
          end
        end
        default: begin
          state <= ST_RUN;
          converting <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // quantiser: clamp and convert to offset binary
  always @* begin
    next_or = 1'b0;
    next_word = sampleIn[9:0] ^ `ACP_WORD_MID; // R1
    if (!sampleIn[11] && (sampleIn[10:9] != 2'b00)) begin
      next_word = `ACP_WORD_ONES; // R3
      next_or = 1'b1; // R6
    end else if (sampleIn[11] && (sampleIn[10:9] != 2'b11)) begin
      next_word = `ACP_WORD_ZERO; // R2
      next_or = 1'b1; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////
  // latency pipeline; last stage is the buffer/output register
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      pipeOr <= {(LAT-1){1'b0}};
      pipeVal <= {(LAT-1){1'b0}};
      for (i = 0; i < LAT-1; i = i + 1)
        pipeWord[i] <= `ACP_WORD_ZERO;
    end else if (ce && bufInReady) begin
      // one sample per enabled clock; stalls only if the buffer fills
      pipeWord[0] <= next_word; // R5 R13
      pipeOr[0] <= next_or; // R14
      pipeVal[0] <= awake; // R11
      for (i = 1; i < LAT-1; i = i + 1)
        pipeWord[i] <= pipeWord[i-1]; // R4
      pipeOr[LAT-2:1] <= pipeOr[LAT-3:0]; // R14
      pipeVal[LAT-2:1] <= pipeVal[LAT-3:0]; // R15
    end
  end

  acp_skid_buf #(
    .WIDTH(11)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .inValid(pipeVal[LAT-2]),
    .inReady(bufInReady),
    .inData({pipeOr[LAT-2], pipeWord[LAT-2]}),
    .outValid(bufOutValid),
    .outReady(wordReady || !wordValid),
    .outData(bufOutData)
  );

  ////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      sample_word_bits <= `ACP_WORD_ZERO;
      outOfRange <= 1'b0;
      wordValid <= 1'b0;
    end else if (ce) begin
      if (wordReady || !wordValid) begin
        wordValid <= bufOutValid;
        if (bufOutValid) begin
          sample_word_bits <= bufOutData[9:0]; // R7
          outOfRange <= bufOutData[10]; // R6 R14
        end
      end
    end
  end
endmodule

// File: acp_map.vh
`ifndef ACP_MAP_VH
`define ACP_MAP_VH
`define ACP_RES_BITS 10
`define ACP_LATENCY 6
`define ACP_CNT_BITS 3
`define ACP_MAX_RATE_MSPS 40
`define ACP_CLK_MHZ 25
`define ACP_WORD_ZERO 10'h000
`define ACP_WORD_ONES 10'h3FF
`define ACP_WORD_MID 10'h200
`define ACP_PT_CAL_LO 0
`define ACP_PT_CAL_HI 1
`endif

// File: acp_skid_buf.v
`timescale 1ns/1ps
module acp_skid_buf #(
  parameter WIDTH = 11
) (
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:1];
  reg wrPtr;
  reg rdPtr;
  reg [1:0] count;
  wire push;
  wire pop;
  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
      mem[0] <= {WIDTH{1'b0}};
      mem[1] <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (push) begin
        mem[wrPtr] <= inData;
        wrPtr <= ~wrPtr;
      end
      if (pop)
        rdPtr <= ~rdPtr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end
endmodule

// File: acp_sample_port_sva.sv
`timescale 1ns/1ps
module acp_sample_port_sva (
  input wire clk_sys,
  input wire rst_b,
  input wire ce,
  input wire reference_source_select,
  input wire sleepCtrl,
  input wire [9:0] sample_word_bits,
  input wire outOfRange,
  input wire wordValid,
  input wire wordReady,
  input wire internalRefOn,
  input wire converting
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_word_hold: assert property (
    wordValid && !wordReady |=> $stable({outOfRange, sample_word_bits}))
    else $error("held word moved");
  a_drop_accept: assert property (
    $fell(wordValid) |-> $past(wordReady && ce)) else $error("word lost");
  a_flag_clamp: assert property (
    wordValid && outOfRange |-> sample_word_bits == 10'h000
    || sample_word_bits == 10'h3FF) else $error("flag without clamp");
  a_ref_track: assert property (
    ce |=> internalRefOn == !$past(reference_source_select))
    else $error("reference choice wrong");
  a_sleep_mode: assert property (
    ce |=> converting == $past(sleepCtrl)) else $error("mode wrong");
  a_ce_freeze: assert property (
    !ce |=> $stable({wordValid, sample_word_bits, converting}))
    else $error("moved while frozen");
  a_reset_quiet: assert property (
    disable iff (1'b0) !rst_b && ce |=> !wordValid && internalRefOn)
    else $error("reset values wrong");
  // slack of two cycles covers skid buffer bubbles while draining
  a_sleep_drain: assert property (
    (ce && wordReady && !converting)[*8] |=> ##2 !wordValid)
    else $error("word while asleep");
  a_stream_rate: assert property (
    (ce && wordReady && converting)[*8] |=> ##1 wordValid)
    else $error("stream gap");
  c_stall: cover property (wordValid && !wordReady);
  c_clamp: cover property (wordValid && wordReady && outOfRange);
  c_sleep: cover property ($fell(converting));
endmodule
bind acp_sample_port acp_sample_port_sva acp_sample_port_sva_i (.*);

// File: acp_capture.sv
`timescale 1ns/1ps
module acp_capture (
  input wire clk_sys,
  input wire stall,
  output reg wordReady
);
  // registered on the converter clock, so never combinational to valid
  initial wordReady = 1'b1;
  always @(posedge clk_sys) begin
    wordReady <= #1 !stall;
  end
endmodule

// File: acp_sample_port_bench.sv
`timescale 1ns/1ps
module acp_sample_port_bench;
  reg clk_sys = 1'b0;
  reg rst_b = 1'b0;
  reg ce = 1'b1;
  reg [11:0] sampleIn = 12'h000;
  reg reference_source_select = 1'b0;
  reg sleepCtrl = 1'b1;
  reg stall = 1'b0;
  wire [9:0] word;
  wire outOfRange, wordValid, wordReady, internalRefOn, converting;
  integer n_errors = 0;
  integer cmp_count = 0;
  integer i;
  always #20 clk_sys = ~clk_sys;
  acp_sample_port acp_sample_port_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .ce(ce), .sampleIn(sampleIn), .sleepCtrl(sleepCtrl),
    .reference_source_select(reference_source_select),
    .sample_word_bits(word), .outOfRange(outOfRange),
    .wordValid(wordValid), .wordReady(wordReady),
    .internalRefOn(internalRefOn), .converting(converting));
  acp_capture acp_capture_i (.clk_sys(clk_sys), .stall(stall),
    .wordReady(wordReady));
  ////////////////////////////////////////////////////////////////////////
  task step(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task ck(input [10:0] got, input [10:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask
  task results;
    $display("errors %0d checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task t_latency;
    step(10);
    sampleIn = 12'h1FF;
    step(1);
    sampleIn = 12'h000;
    step(5);
    ck({wordValid, word}, 11'h600);
    step(1);
    ck({wordValid, word}, 11'h7FF);
  endtask
  task t_code(input [11:0] s, input [10:0] exp);
    sampleIn = s;
    step(8);
    ck({outOfRange, word}, exp);
  endtask
  task t_stall;
    stall = 1'b1;
    step(2);
    sampleIn = 12'h0AA;
    step(20);
    ck({outOfRange, word}, 11'h400);
    stall = 1'b0;
    step(12);
    ck({outOfRange, word}, 11'h2AA);
  endtask
  task t_ref;
    reference_source_select = 1'b1;
    step(1);
    ck(internalRefOn, 1'b0);
    ce = 1'b0;
    reference_source_select = 1'b0;
    step(3);
    ck(internalRefOn, 1'b0);
    ce = 1'b1;
    step(1);
    ck(internalRefOn, 1'b1);
  endtask
  task t_sleep;
    sleepCtrl = 1'b0;
    step(20);
    ck({converting, wordValid}, 2'b00);
    sleepCtrl = 1'b1;
    for (i = 0; i < 20 && wordValid !== 1'b1; i = i + 1)
      step(1);
    ck({converting, wordValid}, 2'b11);
    ck(i > 5, 1'b1);
    if (wordValid !== 1'b1)
      results;
  endtask
  initial begin
    step(3);
    rst_b = 1'b1;
    t_latency;
    t_code(12'h001, 11'h201);
    t_code(12'h1FF, 11'h3FF);
    t_code(12'h200, 11'h7FF);
    t_code(12'hE00, 11'h000);
    t_code(12'hDFF, 11'h400);
    t_code(12'h800, 11'h400);
    t_stall;
    t_ref;
    t_sleep;
    results;
  end
endmodule
